// ==== dyn_term_ctrl.sv ====
// Dynamic on-die termination control with its mode and latency registers.
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "dyn_term_params.svh"

module dyn_term_ctrl (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_termination_control_pin,
  input wire logic i_write_cmd,
  input wire logic i_write_chop,
  input wire logic [`ADDR_W-1:0] i_addr,
  input wire logic [`DATA_W-1:0] i_wr_data,
  input wire logic i_wr_strobe,
  input wire logic i_rd_strobe,
  output logic [`DATA_W-1:0] o_rd_data,
  output logic o_term_on,
  output logic [2:0] o_term_value,
  output logic o_term_unknown,
  output logic o_write_window,
  output logic o_illegal_cfg
);

  // Behaviour at a glance, in clocks of i_clk, with L the shared on and off latency:
  // - The pin sampled at edge k shows on o_term_on from edge k+L until a later
  //   sample says otherwise; a zero strength holds o_term_on low.
  // - A write sampled at edge k opens the write window at edge k+L when dynamic
  //   mode is on at that edge, and the window closes at edge k+L+4 for a chopped
  //   burst or k+L+6 for a full burst, bringing the nominal strength back.
  // - A write that lands inside an open window restarts the window from its own
  //   start and raises no unknown flag, since the strength stays the same.
  // - o_term_unknown marks the one clock in which the strength swaps from nominal
  //   to write; the real swap skew is shorter than a clock, so a whole clock is a
  //   safe superset for anything that samples it.
  // - Mode loads act at their strobe edge and reach the pads one clock later.
  // - A latency change acts at once on events already in the delay line, which
  //   can cut or stretch them; software should change it only while the link idles.
  // - Reserved codes are refused whole: the field keeps its old value and the
  //   sticky illegal flag rises at the strobe edge of the load.
  // - The minimum high times of the pin and the quiet pin around reads are the
  //   controller's duty and are not policed here.
  // - Register reads answer one clock after the strobe and are zero at other times,
  //   so a bus that ORs several slaves together needs no extra gating.
  // - Nothing here raises an interrupt; software polls the status word.

  // Turns the latency settings into the on and off latency, kept at least one.
  // The clamp keeps the delay line tap within its entries for any software setting.
  function automatic logic [4:0] term_latency(input dyn_term_pkg::lat_cfg_s cfg);
    logic [5:0] sum;
    sum = {1'b0, cfg.cwl} + {1'b0, cfg.al};
    if (sum <= `LAT_BIAS) begin
      term_latency = 5'h01;
    end else if ((sum - `LAT_BIAS) > {1'b0, `LAT_MAX}) begin
      term_latency = `LAT_MAX;
    end else begin
      term_latency = 5'(sum - `LAT_BIAS);
    end
  endfunction

  // Maps the write field onto the common strength coding.
  function automatic dyn_term_pkg::term_value_e write_value(input logic [1:0] code);
    case (code)
      2'h1: write_value = dyn_term_pkg::TERM_QUARTER;
      2'h2: write_value = dyn_term_pkg::TERM_HALF;
      default: write_value = dyn_term_pkg::TERM_OFF;
    endcase
  endfunction

  // True while the write window counter still runs; one test for every reader.
  function automatic logic window_active(input logic [2:0] cnt);
    window_active = (cnt != 3'h0);
  endfunction

  // Mode and latency state written by the controller.
  logic [2:0] nom_code_reg;
  logic [2:0] nom_code_next;
  logic [1:0] wr_code_reg;
  logic [1:0] wr_code_next;
  dyn_term_pkg::lat_cfg_s lat_reg;
  dyn_term_pkg::lat_cfg_s lat_next;
  logic illegal_reg;
  logic illegal_next;
  logic [`DATA_W-1:0] rd_data_reg;
  logic [`DATA_W-1:0] rd_data_next;

  // Termination state seen at the pads.
  // All of it is registered, so every pad-facing output leaves a flip-flop.
  logic [2:0] hold_cnt_reg;
  logic [2:0] hold_cnt_next;
  logic term_pin_reg;
  logic term_pin_next;
  logic [2:0] value_reg;
  logic [2:0] value_next;
  logic term_on_reg;
  logic term_on_next;
  logic unknown_reg;
  logic unknown_next;
  // Registered copy of the window test, so the window output leaves a flip-flop.
  logic window_reg;
  logic window_next;

  // Derived controls.
  // These are plain wires, recomputed every clock from registered state and the write and pin inputs.
  logic [4:0] latency;
  logic dyn_enabled;
  logic dyn_write_due;
  logic [2:0] mode1_code;
  logic [1:0] mode2_code;
  dyn_term_pkg::term_events_s events_in;
  dyn_term_pkg::term_events_s events_due;

  assign latency = term_latency(lat_reg);

  // Dynamic mode needs a write code and a running loop.
  assign dyn_enabled = (wr_code_reg != 2'h0) && !lat_reg.dll_off;

  // Field images of the incoming mode load.
  // Nominal field gathered from scattered bits.
  assign mode1_code = {i_wr_data[`MODE1_BIT_HI], i_wr_data[`MODE1_BIT_MID],
                       i_wr_data[`MODE1_BIT_LO]};
  // Write field from two adjacent bits.
  assign mode2_code = {i_wr_data[`MODE2_BIT_HI], i_wr_data[`MODE2_BIT_LO]};

  // Every write variant enters the same delay path.
  // Auto-precharge and fixed or on-the-fly burst forms all arrive as one write pulse.
  assign events_in = '{pin: i_termination_control_pin,
                       chop: i_write_cmd & i_write_chop,
                       write: i_write_cmd};

  // The pin and the writes share one delay line so their timing cannot drift apart.
  // The line is cleared by reset, so no stale event fires after a restart.
  term_delay_line delay_line (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_events(events_in),
    .i_latency(latency),
    .o_events(events_due)
  );

  // A write only changes the strength while dynamic mode is on at the switch point.
  assign dyn_write_due = events_due.write && dyn_enabled;

  // Register file: mode loads, latency setting and the sticky illegal flag.
  // Map: 0x00 holds the nominal field at its mode-register bit places, 0x04 the write
  // field likewise, 0x08 the column and additive latencies and the loop-off bit, and
  // 0x0C the status word. Keeping the mode bits at their native places lets software
  // copy its mode-register images straight in without repacking them.
  // Unused bits read back as zero and writes to them are dropped.
  always_comb begin
    nom_code_next = nom_code_reg;
    wr_code_next = wr_code_reg;
    lat_next = lat_reg;
    illegal_next = illegal_reg;
    if (i_wr_strobe) begin
      case (i_addr)
        `OFS_MODE1: begin
          if (mode1_code >= `NOM_FIRST_RESERVED) begin
            illegal_next = 1'b1;
          end else begin
            nom_code_next = mode1_code;
          end
        end
        `OFS_MODE2: begin
          if (mode2_code == `WR_RESERVED) begin
            illegal_next = 1'b1;
          end else begin
            wr_code_next = mode2_code;
          end
        end
        `OFS_LAT: begin
          lat_next.cwl = i_wr_data[`LAT_CWL_LSB +: 5];
          lat_next.al = i_wr_data[`LAT_AL_LSB +: 5];
          lat_next.dll_off = i_wr_data[`LAT_DLL_OFF_BIT];
        end
        `OFS_STATUS: begin
          // Writing one clears the flag; a fresh illegal load cannot hit this address.
          if (i_wr_data[`ST_ILL_BIT]) begin
            illegal_next = 1'b0;
          end
        end
        default: begin
          // Unmapped writes are ignored.
        end
      endcase
    end
  end

  // Read data appears in the cycle after the strobe and is zero otherwise.
  // Reads have no side effects, so a status poll never clears the illegal flag.
  always_comb begin
    rd_data_next = '0;
    if (i_rd_strobe) begin
      case (i_addr)
        `OFS_MODE1: begin
          rd_data_next[`MODE1_BIT_HI] = nom_code_reg[2];
          rd_data_next[`MODE1_BIT_MID] = nom_code_reg[1];
          rd_data_next[`MODE1_BIT_LO] = nom_code_reg[0];
        end
        `OFS_MODE2: begin
          rd_data_next[`MODE2_BIT_HI] = wr_code_reg[1];
          rd_data_next[`MODE2_BIT_LO] = wr_code_reg[0];
        end
        `OFS_LAT: begin
          rd_data_next[`LAT_CWL_LSB +: 5] = lat_reg.cwl;
          rd_data_next[`LAT_AL_LSB +: 5] = lat_reg.al;
          rd_data_next[`LAT_DLL_OFF_BIT] = lat_reg.dll_off;
        end
        `OFS_STATUS: begin
          rd_data_next[`ST_ON_BIT] = term_on_reg;
          rd_data_next[`ST_VAL_LSB +: 3] = value_reg;
          rd_data_next[`ST_WIN_BIT] = window_reg;
          rd_data_next[`ST_UNK_BIT] = unknown_reg;
          rd_data_next[`ST_DYN_BIT] = dyn_enabled;
          rd_data_next[`ST_ILL_BIT] = illegal_reg;
        end
        default: begin
          rd_data_next = '0;
        end
      endcase
    end
  end

  // Termination sequencing: write window counter, strength and on state.
  // The counter loads its full length at the switch edge and counts down to zero;
  // the strength is picked from the counter's next value so that the window, the
  // strength and the unknown flag all change at the same edge.
  // A restart inside a window reloads the counter and leaves the strength alone.
  always_comb begin
    hold_cnt_next = hold_cnt_reg;
    if (dyn_write_due) begin
      // A write that lands inside a running window restarts it from its own start.
      if (events_due.chop) begin
        hold_cnt_next = `WR_HOLD_CHOP;
      end else begin
        hold_cnt_next = `WR_HOLD_FULL;
      end
    end else if (window_active(hold_cnt_reg)) begin
      hold_cnt_next = hold_cnt_reg - 3'h1;
    end
    // Delayed pin drives on and off.
    term_pin_next = events_due.pin;
    // The window output follows the counter with no extra delay.
    window_next = window_active(hold_cnt_next);
    if (window_next) begin
      value_next = write_value(wr_code_reg);
    end else begin
      value_next = nom_code_reg;
    end
    // Pin gates even the write strength.
    // Nominal off leaves only write bursts.
    term_on_next = term_pin_next && (value_next != 3'h0);
    // Strength unknown as the switch lands.
    unknown_next = dyn_write_due && !window_active(hold_cnt_reg);
  end

  // Register all state; modes come up off with the default latency.
  // Reset clears the window, so no stale write strength survives a reset.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      nom_code_reg <= 3'h0;
      wr_code_reg <= 2'h0;
      lat_reg <= '{cwl: `CWL_RESET, al: `AL_RESET, dll_off: 1'b0};
      illegal_reg <= 1'b0;
      rd_data_reg <= '0;
      hold_cnt_reg <= 3'h0;
      term_pin_reg <= 1'b0;
      value_reg <= 3'h0;
      term_on_reg <= 1'b0;
      unknown_reg <= 1'b0;
      window_reg <= 1'b0;
    end else begin
      nom_code_reg <= nom_code_next;
      wr_code_reg <= wr_code_next;
      lat_reg <= lat_next;
      illegal_reg <= illegal_next;
      rd_data_reg <= rd_data_next;
      hold_cnt_reg <= hold_cnt_next;
      term_pin_reg <= term_pin_next;
      value_reg <= value_next;
      term_on_reg <= term_on_next;
      unknown_reg <= unknown_next;
      window_reg <= window_next;
    end
  end

  // Outputs come straight from flip-flops.
  assign o_rd_data = rd_data_reg;
  assign o_term_on = term_on_reg;
  assign o_term_value = value_reg;
  assign o_term_unknown = unknown_reg;
  assign o_write_window = window_reg;
  assign o_illegal_cfg = illegal_reg;

endmodule
`default_nettype wire

// ==== dyn_term_params.svh ====
// Constants for the dynamic termination block: offsets, fields, resets and counts.
`ifndef DYN_TERM_PARAMS_SVH
`define DYN_TERM_PARAMS_SVH

`define ADDR_W 8
`define DATA_W 32
`define OFS_MODE1 8'h00
`define OFS_MODE2 8'h04
`define OFS_LAT 8'h08
`define OFS_STATUS 8'h0C

`define MODE1_BIT_HI 9
`define MODE1_BIT_MID 6
`define MODE1_BIT_LO 2
`define MODE2_BIT_HI 10
`define MODE2_BIT_LO 9

`define LAT_CWL_LSB 0
`define LAT_AL_LSB 8
`define LAT_DLL_OFF_BIT 16

`define ST_ON_BIT 0
`define ST_VAL_LSB 1
`define ST_WIN_BIT 4
`define ST_UNK_BIT 5
`define ST_DYN_BIT 6
`define ST_ILL_BIT 8

`define CWL_RESET 5'h05
`define AL_RESET 5'h00
`define LAT_BIAS 6'h02
`define LAT_MAX 5'h1F
`define DLY_DEPTH 32

`define WR_HOLD_CHOP 3'h4
`define WR_HOLD_FULL 3'h6

`define NOM_FIRST_RESERVED 3'h6
`define WR_RESERVED 2'h3

`endif

// ==== dyn_term_pkg.sv ====
// Types shared by the dynamic termination block.
package dyn_term_pkg;

  // Termination strength, coded as the nominal mode field.
  typedef enum logic [2:0] {
    TERM_OFF = 3'h0,
    TERM_QUARTER = 3'h1,
    TERM_HALF = 3'h2,
    TERM_SIXTH = 3'h3,
    TERM_TWELFTH = 3'h4,
    TERM_EIGHTH = 3'h5
  } term_value_e;

  // Bits that travel through the latency delay line together.
  typedef struct packed {
    logic pin;
    logic chop;
    logic write;
  } term_events_s;

  // Latency and loop state set by software.
  typedef struct packed {
    logic [4:0] cwl;
    logic [4:0] al;
    logic dll_off;
  } lat_cfg_s;

endpackage

// ==== term_delay_line.sv ====
// Delay line that holds event bits for a programmable number of clocks.
`timescale 1ns/10ps
`default_nettype none
`include "dyn_term_params.svh"

module term_delay_line (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire dyn_term_pkg::term_events_s i_events,
  input wire logic [4:0] i_latency,
  output dyn_term_pkg::term_events_s o_events
);

  // Each entry holds the events sampled that many clocks before the newest.
  dyn_term_pkg::term_events_s hist_reg [0:`DLY_DEPTH-1];
  dyn_term_pkg::term_events_s hist_next [0:`DLY_DEPTH-1];

  // Shift the history by one place and put the new sample at the front.
  always_comb begin
    hist_next[0] = i_events;
    for (int i = 1; i < `DLY_DEPTH; i++) begin
      hist_next[i] = hist_reg[i-1];
    end
  end

  // Register the history; reset clears every event so nothing fires early.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < `DLY_DEPTH; i++) begin
        hist_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < `DLY_DEPTH; i++) begin
        hist_reg[i] <= hist_next[i];
      end
    end
  end

  // The caller registers this tap, so tap L-1 lands exactly L clocks late.
  always_comb begin
    o_events = hist_reg[i_latency - 5'h01];
  end

endmodule
`default_nettype wire

// ==== dyn_term_ctrl_sva.sv ====
// Port checker for the dynamic termination control block.
`timescale 1ns/10ps
`default_nettype none
module dyn_term_ctrl_sva (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_wr_strobe,
  input wire logic i_rd_strobe,
  input wire logic [31:0] o_rd_data,
  input wire logic o_term_on,
  input wire logic [2:0] o_term_value,
  input wire logic o_term_unknown,
  input wire logic o_write_window,
  input wire logic o_illegal_cfg
);
  // One clock domain, so the clock and reset are declared once.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  rd_idle_zero_a: assert property (!$past(i_rd_strobe) |-> o_rd_data == 32'h0)
    else $error("read data not zero outside a read reply");
  unk_in_win_a: assert property (o_term_unknown |-> o_write_window && o_term_value != 3'h0)
    else $error("unknown flag outside a write window");
  unk_pulse_a: assert property (o_term_unknown |=> !o_term_unknown)
    else $error("unknown flag longer than one cycle");
  unk_start_a: assert property ($rose(o_write_window) |-> o_term_unknown)
    else $error("window opened without unknown flag");
  win_min_a: assert property ($rose(o_write_window) |-> o_write_window [*4])
    else $error("write window shorter than four cycles");
  win_end_a: assert property ($fell(o_write_window) |-> $past(o_write_window, 4))
    else $error("write window ended too early");
  zero_off_a: assert property (o_term_value == 3'h0 |-> !o_term_on)
    else $error("termination on with zero strength");
  code_legal_a: assert property (o_term_value <= 3'h5)
    else $error("reserved strength code shown");
  ill_cause_a: assert property ($rose(o_illegal_cfg) |-> $past(i_wr_strobe) || $past(i_wr_strobe, 2))
    else $error("illegal flag set without a write");
  ill_sticky_a: assert property (o_illegal_cfg && !i_wr_strobe |=> o_illegal_cfg)
    else $error("illegal flag dropped without a write");
endmodule
bind dyn_term_ctrl dyn_term_ctrl_sva chk (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_wr_strobe(i_wr_strobe), .i_rd_strobe(i_rd_strobe), .o_rd_data(o_rd_data),
  .o_term_on(o_term_on), .o_term_value(o_term_value), .o_term_unknown(o_term_unknown),
  .o_write_window(o_write_window), .o_illegal_cfg(o_illegal_cfg));
`default_nettype wire

// ==== term_controller.sv ====
// Memory controller model driving the termination pin and write commands.
`timescale 1ns/10ps
`default_nettype none
module term_controller (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_go,
  input wire logic i_chop,
  input wire logic i_with_write,
  input wire logic [3:0] i_hold,
  output logic o_pin,
  output logic o_write_cmd,
  output logic o_write_chop
);
  int need; // Minimum high clocks owed for this request.
  int left; // Clocks the pin must still stay high.
  always_comb begin
    need = (i_with_write && !i_chop) ? 6 : 4;
    if (int'(i_hold) > need) begin
      need = int'(i_hold);
    end
  end
  // A new request never shortens a hold still owed to an earlier write.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      left <= 0;
      o_pin <= 1'b0;
      o_write_cmd <= 1'b0;
      o_write_chop <= 1'b0;
    end else begin
      o_write_cmd <= i_go && i_with_write;
      o_write_chop <= i_chop;
      if (i_go) begin
        o_pin <= 1'b1;
        left <= (need - 1 > left) ? need - 1 : left;
      end else if (left > 0) begin
        left <= left - 1;
      end else begin
        o_pin <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== test_dyn_term_ctrl.sv ====
// Self-checking bench for the dynamic termination control block.
`timescale 1ns/10ps
`default_nettype none
module test_dyn_term_ctrl;
  logic i_clk, i_reset_n, pin, wcmd, wchop, wr, rd, go, chop, with_wr, on, unk, win, ill;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, seed = 32'hFBDCD256;
  logic [3:0] hold;
  logic [2:0] val, ev;
  int err_count = 0, comparisons = 0, cyc = 0, k = 0, cnt = 0, eunk = 0;
  int nom = 0, wc = 0, lat = 3, dll = 0, eill = 0, c, a, code = 0;
  logic eon = 1'b0; // Expected on state for the current cycle.
  bit [8191:0] ph, wh, ch; // Sampled pin, write and chop by edge number.
  dyn_term_ctrl dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_termination_control_pin(pin),
    .i_write_cmd(wcmd), .i_write_chop(wchop), .i_addr(addr), .i_wr_data(wdata),
    .i_wr_strobe(wr), .i_rd_strobe(rd), .o_rd_data(rdata), .o_term_on(on),
    .o_term_value(val), .o_term_unknown(unk), .o_write_window(win), .o_illegal_cfg(ill));
  term_controller ctl (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_go(go), .i_chop(chop),
    .i_with_write(with_wr), .i_hold(hold), .o_pin(pin), .o_write_cmd(wcmd),
    .o_write_chop(wchop));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  // Xorshift source so every run sees the same stimulus.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] img1(input int n);
    return {22'h0, n[2], 2'b0, n[1], 3'b0, n[0], 2'b0};
  endfunction
  task automatic check(input logic [31:0] got, exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] ad, input logic [31:0] d);
    @(posedge i_clk);
    wr <= 1'b1;
    addr <= ad;
    wdata <= d;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] ad, input logic [31:0] m, exp);
    @(posedge i_clk);
    rd <= 1'b1;
    addr <= ad;
    @(posedge i_clk);
    rd <= 1'b0;
    @(negedge i_clk);
    check(rdata & m, exp, "register read");
  endtask
  // Loads all three registers; the model follows each load at its strobe edge.
  task automatic cfg(input int n, w, cw, al, d);
    wreg(8'h00, img1(n));
    wreg(8'h04, {21'h0, w[1], w[0], 9'h0});
    wreg(8'h08, {15'h0, d[0], 3'h0, al[4:0], 3'h0, cw[4:0]});
    rreg(8'h00, 32'h244, img1(nom));
    rreg(8'h04, 32'h600, {21'h0, wc[1:0], 9'h0});
    rreg(8'h08, 32'h11F1F, {15'h0, d[0], 3'h0, al[4:0], 3'h0, cw[4:0]});
    rreg(8'h0C, 32'h140, {23'h0, eill[0], 1'b0, wc != 0 && dll == 0, 6'h0});
  endtask
  task give_verdict;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Reference model: replays sampled pin and writes after the set latency, then
  // applies any register load seen at this edge, which the pads show a clock later.
  always @(posedge i_clk) begin
    if (i_reset_n) begin
      cyc = cyc + 1;
      ph[cyc] = pin;
      wh[cyc] = wcmd;
      ch[cyc] = wchop;
      k = cyc - lat;
      eunk = 0;
      if (k > 0 && wh[k] && wc != 0 && dll == 0) begin
        eunk = (cnt == 0);
        cnt = ch[k] ? 4 : 6;
      end else if (cnt > 0) begin
        cnt = cnt - 1;
      end
      ev = (cnt > 0) ? wc[2:0] : nom[2:0];
      eon = k > 0 && ph[k] && ev != 0;
      if (wr && addr == 8'h00) begin
        code = {wdata[9], wdata[6], wdata[2]};
        if (code < 6) begin
          nom = code;
        end else begin
          eill = 1;
        end
      end
      if (wr && addr == 8'h04) begin
        code = {wdata[10], wdata[9]};
        if (code < 3) begin
          wc = code;
        end else begin
          eill = 1;
        end
      end
      if (wr && addr == 8'h08) begin
        lat = int'(wdata[4:0]) + int'(wdata[12:8]) - 2;
        lat = (lat < 1) ? 1 : (lat > 31) ? 31 : lat;
        dll = wdata[16];
      end
      if (wr && addr == 8'h0C && wdata[8]) begin
        eill = 0;
      end
    end
  end
  // Outputs settle by the falling edge; compare the termination outputs every cycle.
  always @(negedge i_clk) begin
    if (i_reset_n && cyc > 0) begin
      check({on, val, unk, win}, {eon, ev, eunk[0], cnt > 0}, "term");
    end
  end
  initial begin
    #1000000;
    err_count++;
    give_verdict;
  end
  initial begin
    i_reset_n = 1'b0;
    {go, chop, with_wr, wr, rd, hold, addr, wdata} = '0;
    repeat (3) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rreg(8'h08, 32'h11F1F, 32'h5);
    rreg(8'h0C, 32'h17F, 32'h0);
    rreg(8'h10, 32'hFFFFFFFF, 32'h0);
    for (int i = 0; i < 14; i++) begin
      c = 5 + rnd() % 4;
      a = rnd() % 3;
      // Dynamic off pairs only with nominal off or one sixth.
      // Last pass: nominal off, pin held long.
      cfg((i == 13) ? 0 : i % 6, i % 3, c, a, i == 12);
      if (i == 7) cfg(6 + i % 2, 3, c, a, 0);
      if (i == 9) wreg(8'h0C, 32'h100);
      wreg(8'h14, rnd());
      repeat (6) begin
        // At least one idle clock keeps every go pulse a single-cycle strobe.
        repeat (1 + rnd() % 8) @(posedge i_clk);
        go <= 1'b1;
        chop <= rnd() % 2;
        with_wr <= (rnd() % 4) != 0;
        hold <= (i == 13) ? 4'hF : 4'(rnd() % 9);
        @(posedge i_clk);
        go <= 1'b0;
      end
      repeat (40) @(posedge i_clk);
    end
    give_verdict;
  end
endmodule
`default_nettype wire
